// ### psi_top.sv
// PLL status interrupt logic: edge-detected sticky flags with selectable polarity,
// mask, AND/OR combine, enable for flag setting and status_irq, live source view and slew indicators.
// Assumes all inputs are synchronous to sys_clk and an APB master on the bus.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module psi_top
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Internal status sources
	input wire psi_pkg::psi_src_t src_in,
	input wire psi_pkg::psi_slew_t slew_in,
	// Interrupt outputs
	output logic status_irq,
	output logic sys_irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0] src_ff; // Sources as seen last cycle
	logic [7:0] src_eff; // Sources after precedence fix
	logic [3:0] slew_ff; // Registered slew indicators
	logic [7:0] pol_ff; // Edge select per source
	logic [7:0] mask_ff; // Mask per source
	logic [7:0] flags_ff; // Sticky flags
	logic [7:0] nxt_flags; // Next sticky flags
	logic ctl_en_ff; // Interrupt circuit enable
	logic ctl_and_ff; // Combine mode
	logic [1:0] sys_stat_ff; // Sticky block events
	logic [1:0] sys_en_ff; // Block event enables
	logic [1:0] sys_ev; // Block event pulses
	logic [7:0] rise; // Rising edges this cycle
	logic [7:0] fall; // Falling edges this cycle
	logic [7:0] set_vec; // Flags to set this cycle
	logic [7:0] unmasked; // Unmasked flags
	logic combine_hit; // Combination result
	logic status_irq_ff; // Status pin interrupt
	logic sys_irq_ff; // Block interrupt
	logic [31:0] prdata_ff; // Read data
	logic pready_ff; // Ready
	logic pslverr_ff; // Error
	logic setup; // APB setup phase
	logic wr_acc; // Write completes this edge
	logic acc_done; // Any transfer completes this edge
	logic [31:0] rd_mux; // Read data selected
	logic mapped; // Address is mapped

	// Match a byte address against a register index
	function automatic logic reg_sel(input logic [7:0] addr, input logic [5:0] idx);
		reg_sel = (addr == {idx, 2'b00});
	endfunction

	// ------------------------------------------------------------
	// Source conditioning and edge detection
	// ------------------------------------------------------------
	// Lock loss caused by input loss is reported as input loss only
	always_comb
	begin
		src_eff = src_in;
		src_eff[7] = src_in.pll1_lock_lost & ~src_in.pll1_input_lost;
		src_eff[4] = src_in.pll2_lock_lost & ~src_in.pll2_input_lost;
	end

	// Previous-cycle copy of the sources; also the live view
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			src_ff <= 8'h00;
			slew_ff <= 4'h0;
		end
		else
		begin
			src_ff <= src_eff;
			slew_ff <= slew_in;
		end
	end

	// Edge compare against last cycle; polarity picks which edge counts
	assign rise = src_eff & ~src_ff;
	assign fall = ~src_eff & src_ff;
	assign set_vec = ctl_en_ff ? ((pol_ff & rise) | (~pol_ff & fall)) : 8'h00;

	// ------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------
	assign setup = psel & ~penable;
	assign acc_done = psel & penable & pready_ff;
	assign wr_acc = acc_done & pwrite;
	assign mapped = reg_sel(paddr, psi_pkg::IDX_SOURCE_LEVEL_VIEW) | reg_sel(paddr, psi_pkg::IDX_FLAG_MASK)
		| reg_sel(paddr, psi_pkg::IDX_FLAG_EDGE_POLARITY) | reg_sel(paddr, psi_pkg::IDX_STICKY_EVENT_FLAGS)
		| reg_sel(paddr, psi_pkg::IDX_EVENT_COMBINE_CONTROL) | reg_sel(paddr, psi_pkg::IDX_REFERENCE_SLEW_VALID)
		| reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_STATUS) | reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_CLEAR)
		| reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_ENABLE);

	// Read multiplexer; reserved bits and write-only registers read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (reg_sel(paddr, psi_pkg::IDX_SOURCE_LEVEL_VIEW))
			rd_mux[7:0] = src_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_FLAG_MASK))
			rd_mux[7:0] = mask_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_FLAG_EDGE_POLARITY))
			rd_mux[7:0] = pol_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_STICKY_EVENT_FLAGS))
			rd_mux[7:0] = flags_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_EVENT_COMBINE_CONTROL))
		begin
			rd_mux[psi_pkg::CTL_COMBINE_BIT] = ctl_and_ff;
			rd_mux[psi_pkg::CTL_ENABLE_BIT] = ctl_en_ff;
		end
		else if (reg_sel(paddr, psi_pkg::IDX_REFERENCE_SLEW_VALID))
			rd_mux[7:psi_pkg::SLEW_LSB] = slew_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_STATUS))
			rd_mux[1:0] = sys_stat_ff;
		else if (reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_ENABLE))
			rd_mux[1:0] = sys_en_ff;
	end

	// Answer is prepared in the setup cycle, so the access phase never waits
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else if (setup)
		begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
			pready_ff <= 1'b1;
			pslverr_ff <= ~mapped;
		end
		else
		begin
			// Drop the answer after each access phase
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Polarity, mask and control, written at the completing edge
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pol_ff <= psi_pkg::RST_POLARITY;
			mask_ff <= psi_pkg::RST_MASK;
			ctl_and_ff <= psi_pkg::RST_CONTROL[psi_pkg::CTL_COMBINE_BIT];
			ctl_en_ff <= psi_pkg::RST_CONTROL[psi_pkg::CTL_ENABLE_BIT];
		end
		else if (wr_acc)
		begin
			if (reg_sel(paddr, psi_pkg::IDX_FLAG_EDGE_POLARITY))
				pol_ff <= pwdata[7:0];
			if (reg_sel(paddr, psi_pkg::IDX_FLAG_MASK))
				mask_ff <= pwdata[7:0];
			if (reg_sel(paddr, psi_pkg::IDX_EVENT_COMBINE_CONTROL))
			begin
				ctl_and_ff <= pwdata[psi_pkg::CTL_COMBINE_BIT];
				ctl_en_ff <= pwdata[psi_pkg::CTL_ENABLE_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Sticky flags
	// ------------------------------------------------------------
	// Writing 0 clears a bit, writing 1 keeps it; a new edge beats the clear
	always_comb
	begin
		nxt_flags = flags_ff;
		if (wr_acc && reg_sel(paddr, psi_pkg::IDX_STICKY_EVENT_FLAGS))
			nxt_flags = flags_ff & pwdata[7:0];
		nxt_flags = nxt_flags | set_vec;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			flags_ff <= psi_pkg::RST_FLAGS;
		else
			flags_ff <= nxt_flags;
	end

	// ------------------------------------------------------------
	// Combination onto the status pin
	// ------------------------------------------------------------
	// AND mode needs at least one unmasked source, else it would fire with none
	assign unmasked = flags_ff & ~mask_ff;
	assign combine_hit = ctl_and_ff ? ((unmasked == ~mask_ff) && (mask_ff != 8'hff))
		: (unmasked != 8'h00);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			status_irq_ff <= 1'b0;
		else
			status_irq_ff <= ctl_en_ff & combine_hit;
	end

	// ------------------------------------------------------------
	// Block event interrupt
	// ------------------------------------------------------------
	assign sys_ev = {acc_done & pslverr_ff, (set_vec & ~flags_ff) != 8'h00};

	// Sticky status, write-1 clear, set wins over clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sys_stat_ff <= psi_pkg::RST_SYS;
			sys_en_ff <= psi_pkg::RST_SYS;
			sys_irq_ff <= 1'b0;
		end
		else
		begin
			if (wr_acc && reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_CLEAR))
				sys_stat_ff <= (sys_stat_ff & ~pwdata[1:0]) | sys_ev;
			else
				sys_stat_ff <= sys_stat_ff | sys_ev;
			if (wr_acc && reg_sel(paddr, psi_pkg::IDX_SYS_IRQ_ENABLE))
				sys_en_ff <= pwdata[1:0];
			sys_irq_ff <= (sys_stat_ff & sys_en_ff) != 2'b00;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign status_irq = status_irq_ff;
	assign sys_irq = sys_irq_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Helper: write completing on the flag register
	logic flag_wr;
	assign flag_wr = wr_acc & reg_sel(paddr, psi_pkg::IDX_STICKY_EVENT_FLAGS);

	AST_RISE_SETS: assert property ((ctl_en_ff && ((pol_ff & rise) != 8'h00))
		|=> ((flags_ff & $past(pol_ff & rise)) == $past(pol_ff & rise)))
		else $error("rising edge did not set its flag");
	AST_FALL_SETS: assert property ((ctl_en_ff && ((~pol_ff & fall) != 8'h00))
		|=> ((flags_ff & $past(~pol_ff & fall)) == $past(~pol_ff & fall)))
		else $error("falling edge did not set its flag");
	AST_FLAG_STICKY: assert property (!flag_wr |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
		else $error("flag cleared without a write");
	AST_NO_SET_WHEN_OFF: assert property (!ctl_en_ff |=> ((flags_ff & ~$past(flags_ff)) == 8'h00))
		else $error("flag set while disabled");
	AST_AND_MODE: assert property ((ctl_en_ff && ctl_and_ff && (mask_ff != 8'hff))
		|=> (status_irq_ff == ($past(flags_ff | mask_ff) == 8'hff)))
		else $error("AND combination wrong");
	AST_OR_MODE: assert property ((ctl_en_ff && !ctl_and_ff)
		|=> (status_irq_ff == ($past(flags_ff & ~mask_ff) != 8'h00)))
		else $error("OR combination wrong");
	AST_OFF_NO_IRQ: assert property (!ctl_en_ff |=> !status_irq_ff)
		else $error("status interrupt while disabled");
	AST_LIVE_VIEW: assert property (##1 ((src_ff[6:5] == $past(src_in[6:5])) && (src_ff[3:0] == $past(src_in[3:0]))))
		else $error("live view does not follow sources");
	AST_SLEW_VIEW: assert property (##1 (slew_ff == $past(slew_in)))
		else $error("slew indicators not shown");
	AST_ALL_MASKED: assert property ((mask_ff == 8'hff) |=> !status_irq_ff)
		else $error("masked flags drove the interrupt");
	AST_LOS_PRECEDENCE: assert property (!(src_ff[7] && src_ff[6]) && !(src_ff[4] && src_ff[3]))
		else $error("lock loss reported with input loss");

	COV_FLAG_SET: cover property (ctl_en_ff && (set_vec != 8'h00) ##1 (flags_ff != 8'h00));
	COV_FLAG_CLEAR: cover property (flag_wr && (flags_ff != 8'h00) ##1 (flags_ff == 8'h00));
	COV_AND_IRQ: cover property (ctl_and_ff && status_irq_ff);
	COV_BUS_ERR: cover property (acc_done && pslverr_ff);

endmodule

// ### psi_pkg.sv
// Package for the PLL status interrupt logic: register map, field layouts,
// reset values and the packed carriers for the source and slew-detector levels.
// Assumes an APB slave with 32-bit data and byte addresses of four times the index.
package psi_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_SOURCE_LEVEL_VIEW = 6'h0d; // Live source levels, read only
	localparam logic [5:0] IDX_FLAG_MASK = 6'h0e; // Per-source mask
	localparam logic [5:0] IDX_FLAG_EDGE_POLARITY = 6'h0f; // Per-source edge select
	localparam logic [5:0] IDX_STICKY_EVENT_FLAGS = 6'h10; // Sticky flags, write 0 clears
	localparam logic [5:0] IDX_EVENT_COMBINE_CONTROL = 6'h11; // Combine mode and enable
	localparam logic [5:0] IDX_REFERENCE_SLEW_VALID = 6'h12; // Slew-detector indicators
	localparam logic [5:0] IDX_SYS_IRQ_STATUS = 6'h20; // Sticky block events, read only
	localparam logic [5:0] IDX_SYS_IRQ_CLEAR = 6'h21; // Write 1 to clear, write only
	localparam logic [5:0] IDX_SYS_IRQ_ENABLE = 6'h22; // Enables for block events

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_ENABLE_BIT = 0; // Interrupt circuit enable
	localparam int CTL_COMBINE_BIT = 1; // 1 = AND of unmasked flags, 0 = OR
	localparam int SLEW_LSB = 4; // Slew indicators sit in bits 7..4
	localparam int SYS_EV_FLAG_SET = 0; // A sticky flag was newly set
	localparam int SYS_EV_BUS_ERR = 1; // Access to an unmapped address

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	localparam logic [1:0] RST_SYS = 2'h0;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// Eight interrupt sources, bit 7 down to bit 0
	typedef struct packed {
		logic pll1_lock_lost;
		logic pll1_input_lost;
		logic pll1_vco_tuning;
		logic pll2_lock_lost;
		logic pll2_input_lost;
		logic pll2_vco_tuning;
		logic pll1_back_to_primary;
		logic pll2_back_to_primary;
	} psi_src_t;

	// Slew-rate detector validity, bit 7 down to bit 4
	typedef struct packed {
		logic second_ref_rise_ok;
		logic second_ref_fall_ok;
		logic first_ref_rise_ok;
		logic first_ref_fall_ok;
	} psi_slew_t;

endpackage

// ### testbench.sv
// Self-checking bench for the PLL status interrupt logic, driving APB and source levels.
// Assumes psi_pkg and psi_top are compiled first; one 250 MHz clock, active-high async reset.
`timescale 1ns/1ps

module testbench;

	// ------------------------------------------------------------
	// Signals and byte addresses
	// ------------------------------------------------------------
	logic sys_clk; // 250 MHz clock
	logic rst; // Active-high reset
	logic psel, penable, pwrite; // APB request
	logic [7:0] paddr; // APB byte address
	logic [31:0] pwdata; // APB write data
	logic [31:0] prdata; // APB read data
	logic pready, pslverr; // APB answer
	psi_pkg::psi_src_t src_in; // Source levels
	psi_pkg::psi_slew_t slew_in; // Slew-detector levels
	logic status_irq, sys_irq; // Interrupt outputs
	int miscompares; // Mismatch count
	int cmp_count; // Comparison count
	logic [31:0] rd; // Last read data
	logic er; // Last error response
	localparam logic [7:0] A_LIVE = {psi_pkg::IDX_SOURCE_LEVEL_VIEW, 2'h0};
	localparam logic [7:0] A_MASK = {psi_pkg::IDX_FLAG_MASK, 2'h0};
	localparam logic [7:0] A_POL = {psi_pkg::IDX_FLAG_EDGE_POLARITY, 2'h0};
	localparam logic [7:0] A_FLAG = {psi_pkg::IDX_STICKY_EVENT_FLAGS, 2'h0};
	localparam logic [7:0] A_CTL = {psi_pkg::IDX_EVENT_COMBINE_CONTROL, 2'h0};
	localparam logic [7:0] A_SLEW = {psi_pkg::IDX_REFERENCE_SLEW_VALID, 2'h0};
	localparam logic [7:0] A_SST = {psi_pkg::IDX_SYS_IRQ_STATUS, 2'h0};
	localparam logic [7:0] A_SCLR = {psi_pkg::IDX_SYS_IRQ_CLEAR, 2'h0};
	localparam logic [7:0] A_SEN = {psi_pkg::IDX_SYS_IRQ_ENABLE, 2'h0};
	logic [7:0] all_regs [9] = '{A_LIVE, A_MASK, A_POL, A_FLAG, A_CTL, A_SLEW, A_SST, A_SCLR, A_SEN};

	// Device under test
	psi_top i_psi_top
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.src_in(src_in),
		.slew_in(slew_in),
		.status_irq(status_irq),
		.sys_irq(sys_irq)
	);

	// Free-running clock, 4 ns period
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Helper tasks
	// ------------------------------------------------------------
	// Prints counts and verdict, then stops
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Compares a seen value with the expected one
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer: setup, then access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
		begin
			// A slave that never answers ends the run
			if (n == 20)
			begin
				miscompares++;
				tally_and_finish();
			end
			n++;
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
	endtask

	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Register read with compare
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	// New source levels, then time for edge detection to land
	task automatic set_src(input logic [7:0] v);
		@(posedge sys_clk);
		src_in <= v;
		repeat (2) @(posedge sys_clk);
	endtask

	// Lets the registered interrupt outputs follow their causes
	task automatic settle();
		repeat (3) @(posedge sys_clk);
	endtask

	// Hang guard
	initial
	begin
		#100000;
		miscompares++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		src_in = '0;
		slew_in = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		// Every register reads zero after reset
		for (int i = 0; i < 9; i++)
			rchk("reset value", all_regs[i], 32'h0);
		chk("status_irq", 32'(status_irq), 32'h0);
		chk("sys_irq", 32'(sys_irq), 32'h0);
		// Mask and polarity registers keep eight bits only
		wr(A_MASK, 32'h5a);
		rchk("mask", A_MASK, 32'h5a);
		wr(A_MASK, 32'h0);
		wr(A_POL, 32'hffffffff);
		rchk("polarity", A_POL, 32'hff);
		// Slew indicators land in bits 7..4, read-only
		@(posedge sys_clk);
		slew_in <= 4'ha;
		wr(A_SLEW, 32'h0);
		rchk("slew", A_SLEW, 32'ha0);
		// Disabled circuit ignores edges but the live view follows
		set_src(8'h3f);
		rchk("flags disabled", A_FLAG, 32'h0);
		// Bit 4 stays hidden because bit 3 (input loss of the same PLL) is also high
		rchk("live view", A_LIVE, 32'h2f);
		settle();
		chk("status_irq disabled", 32'(status_irq), 32'h0);
		set_src(8'h00);
		// Enabled, OR mode: each rising edge sets its own flag only
		wr(A_CTL, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			set_src(8'h01 << i);
			rchk("rise flag", A_FLAG, 32'h1 << i);
			chk("status_irq or", 32'(status_irq), 32'h1);
			set_src(8'h00);
			rchk("flag held", A_FLAG, 32'h1 << i);
			wr(A_FLAG, 32'h0);
			rchk("flag cleared", A_FLAG, 32'h0);
		end
		// Input loss hides lock loss of the same PLL
		set_src(8'hc0);
		rchk("live suppress", A_LIVE, 32'h40);
		rchk("flag suppress", A_FLAG, 32'h40);
		set_src(8'h00);
		wr(A_FLAG, 32'h0);
		// Polarity zero: only falling edges set flags
		wr(A_POL, 32'h0);
		set_src(8'h3f);
		rchk("no rise flag", A_FLAG, 32'h0);
		set_src(8'h00);
		rchk("fall flags", A_FLAG, 32'h2f);
		wr(A_FLAG, 32'hfe);
		rchk("single clear", A_FLAG, 32'h2e);
		// AND mode needs every unmasked flag; bit 4 can never set here, so mask it
		wr(A_MASK, 32'hd0);
		wr(A_CTL, 32'h3);
		settle();
		chk("status_irq and partial", 32'(status_irq), 32'h0);
		set_src(8'h01);
		set_src(8'h00);
		rchk("and flags", A_FLAG, 32'h2f);
		settle();
		chk("status_irq and full", 32'(status_irq), 32'h1);
		wr(A_MASK, 32'h0);
		settle();
		chk("status_irq and unmasked", 32'(status_irq), 32'h0);
		// OR mode with every source masked, then unmasked
		wr(A_MASK, 32'hff);
		wr(A_CTL, 32'h1);
		settle();
		chk("status_irq all masked", 32'(status_irq), 32'h0);
		wr(A_MASK, 32'h0);
		settle();
		chk("status_irq or again", 32'(status_irq), 32'h1);
		// Disabling silences the pin and keeps the flags
		wr(A_CTL, 32'h2);
		settle();
		chk("status_irq off", 32'(status_irq), 32'h0);
		rchk("control", A_CTL, 32'h2);
		rchk("flags kept", A_FLAG, 32'h2f);
		// Block event interrupt: new-flag event seen, bus error raises, mask, clear
		rchk("sys status flag", A_SST, 32'h1);
		wr(A_SCLR, 32'h3);
		rchk("sys status clear", A_SST, 32'h0);
		wr(A_SEN, 32'h2);
		rchk("unmapped", 8'hfc, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		rchk("sys status err", A_SST, 32'h2);
		settle();
		chk("sys_irq raised", 32'(sys_irq), 32'h1);
		wr(A_SEN, 32'h0);
		settle();
		chk("sys_irq masked", 32'(sys_irq), 32'h0);
		wr(A_SEN, 32'h2);
		wr(A_SCLR, 32'h2);
		rchk("sys clear reads", A_SCLR, 32'h0);
		rchk("sys status cleared", A_SST, 32'h0);
		chk("sys_irq cleared", 32'(sys_irq), 32'h0);
		// Write to a read-only register is ignored without error
		wr(A_LIVE, 32'hff);
		chk("ro slverr", 32'(er), 32'h0);
		rchk("ro live", A_LIVE, 32'h0);
		tally_and_finish();
	end

endmodule
